// File: design/jdm_access_regs.svh
// Constants for the JTAG debug module access block
`ifndef JDM_ACCESS_REGS_SVH
`define JDM_ACCESS_REGS_SVH

// ==========================================================
// TAP instruction codes
`define JDM_IR_WIDTH 5
`define JDM_IR_IDCODE 5'h01
`define JDM_IR_XPORT_STATUS 5'h10
`define JDM_IR_ACCESS 5'h11
`define JDM_IR_BYPASS 5'h1F
`define JDM_IR_CAPTURE 5'h01

// ==========================================================
// Debug access scan register layout
`define JDM_SCAN_WIDTH 41
`define JDM_ADDR_HI 40
`define JDM_ADDR_LO 34
`define JDM_DATA_HI 33
`define JDM_DATA_LO 2
`define JDM_OPC_HI 1
`define JDM_OPC_LO 0
`define JDM_SCAN_RESET 41'h000_0000_0000
`define JDM_OPC_NOP 2'h0
`define JDM_OPC_READ 2'h1
`define JDM_OPC_WRITE 2'h2
`define JDM_OPC_OK 2'h0

// ==========================================================
// Debug module offsets (module base is zero)
`define JDM_MOD_BASE 7'h00
`define JDM_OFF_DATA0 7'h04
`define JDM_OFF_DATA1 7'h05
`define JDM_OFF_CONTROL 7'h10
`define JDM_OFF_STATUS 7'h11
`define JDM_OFF_ABS_STATUS 7'h16
`define JDM_OFF_COMMAND 7'h17
`define JDM_OFF_SB_STATUS 7'h38
`define JDM_OFF_SB_ADDR 7'h39
`define JDM_OFF_SB_DATA0 7'h3C
`define JDM_OFF_SB_DATA1 7'h3D
`define JDM_OFF_HALT_SUMMARY 7'h40

// ==========================================================
// Control register fields
`define JDM_CTL_HALTREQ 31
`define JDM_CTL_RESUMEREQ 30
`define JDM_CTL_ACKRESET 28

// ==========================================================
// Transport status fields and module version
`define JDM_XS_ABITS 6'h07
`define JDM_XS_VERSION 4'h1
`define JDM_MOD_VERSION 4'h2

`endif

// File: design/jdm_pkg.sv
// Types for the JTAG debug module access block
package jdm_pkg;

    // ======================================================
    // TAP controller states
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
        TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } jdm_tap_t;

    // ======================================================
    // Launched module request
    typedef struct packed {
        logic [6:0] addr;
        logic [31:0] data;
        logic [1:0] opc;
    } jdm_req_t;

    // ======================================================
    // System bus request
    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [31:0] data;
    } jdm_sbreq_t;

endpackage

// File: design/jdm_access.sv
// JTAG debug transport and debug module register access
// Functional notes
// [RQ1] Update-DR with access register selected launches the encoded operation.
// [RQ2] Capture-DR loads the data field with the previous operation's result.
// [RQ3] Debugger should check each access result rather than batching scans.
// [RQ4] Access register is 41 bits: address 40:34, data 33:2, code 1:0.
// [RQ5] Operation codes: 0 nothing, 1 read, 2 write; 3 unused.
// [RQ6] Shifted-out operation field always reads zero, meaning success.
// [RQ7] Address field picks the module register targeted at Update-DR.
// [RQ8] Instruction 0x11 selects the access register.
// [RQ9] Bypass is one flip-flop, reset zero, adding one bit delay.
// [RQ10] All instructions except 0x01, 0x10, 0x11 select bypass.
// [RQ11] Module decodes data0, data1, control, status, abstract, bus, summary offsets.
// [RQ12] One debug module at base zero; offsets are absolute addresses.
// [RQ13] Core memories via abstract command only; SoC memory via bus path only.
// [RQ14] Debugger sets at most one of resume and reset-ack per write.
// [RQ15] Control bit 31 writes the halt latch, reads zero; hart halts while set.
// [RQ16] Control bit 30 written one resumes a halted hart unless halt latched.
// [RQ17] Control bit 29 hart reset is absent and reads zero.
// [RQ18] Control bit 28 written one clears sticky has-been-reset; reads zero.
// [RQ19] Control bit 27 reserved zero; bit 26 selector reads zero.
// [RQ20] Instruction register is five bits and selects the data path.
// [RQ21] Transport status reports an address width of seven bits.
// [RQ22] Requests and results cross clock domains by toggle handshake.
`timescale 1ns/1ps
`include "jdm_access_regs.svh"

module jdm_access
    import jdm_pkg::*;
#(
    // Arbitrary identification value
    parameter logic [31:0] ID_VALUE = 32'h0000_0001
) (
    // Core clock and reset
    input wire logic clk,
    input wire logic rst,
    // JTAG pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdoEn,
    // Hart status
    input wire logic hartHalted,
    input wire logic hartRunning,
    input wire logic hartUnavail,
    input wire logic hartResetSeen,
    input wire logic hartResumed,
    // Hart control
    output logic haltReq,
    output logic resumeReq,
    output logic ackHaveReset,
    // Abstract command path
    output logic absCmdValid,
    output logic [31:0] absCmd,
    // System bus path
    output jdm_sbreq_t sbReq
);

    // ======================================================
    // TAP controller (link clock)
    jdm_tap_t tap_r;
    jdm_tap_t tap_nxt;

    always_comb begin
        tap_nxt = tap_r;
        case (tap_r)
            TAP_RESET: tap_nxt = tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tap_nxt = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_nxt = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_nxt = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tap_nxt = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tap_nxt = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tap_nxt = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tap_nxt = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: tap_nxt = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_nxt = tms ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_nxt = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tap_nxt = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tap_nxt = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tap_nxt = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tap_nxt = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: tap_nxt = tms ? TAP_SEL_DR : TAP_IDLE;
            default: tap_nxt = TAP_RESET;
        endcase
    end

    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            tap_r <= TAP_RESET;
        end else begin
            tap_r <= tap_nxt;
        end
    end

    // ======================================================
    // Instruction register and data path selection
    logic [4:0] irShift_r;
    logic [4:0] ir_r;
    wire selAccess = (ir_r == `JDM_IR_ACCESS); // [RQ8]
    wire selId = (ir_r == `JDM_IR_IDCODE);
    wire selXs = (ir_r == `JDM_IR_XPORT_STATUS);
    wire selBypass = !(selAccess || selId || selXs); // [RQ10]
    wire [31:0] xportStatus = {14'h0000, 2'b00, 1'b0, 3'h0, 2'b00, `JDM_XS_ABITS,
        `JDM_XS_VERSION}; // [RQ21]

    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            irShift_r <= 5'h00;
            ir_r <= `JDM_IR_IDCODE;
        end else begin
            if (tap_r == TAP_CAP_IR) begin
                irShift_r <= `JDM_IR_CAPTURE;
            end else if (tap_r == TAP_SHIFT_IR) begin
                irShift_r <= {tdi, irShift_r[4:1]}; // [RQ20]
            end
            if (tap_r == TAP_RESET) begin
                ir_r <= `JDM_IR_IDCODE;
            end else if (tap_r == TAP_UPD_IR) begin
                ir_r <= irShift_r; // [RQ20]
            end
        end
    end

    // ======================================================
    // Data shift registers, launch and result return (link clock)
    logic [40:0] dr_r;
    logic bypass_r;
    jdm_req_t launch_r;
    logic reqTgl_r;
    logic ackSync1_r;
    logic ackSync2_r;
    logic ackSeen_r;
    logic [31:0] result_r;
    logic [31:0] respWord_r;
    logic ackTgl_r;

    wire [1:0] scanOpc = dr_r[`JDM_OPC_HI:`JDM_OPC_LO];
    wire launchGo = (tap_r == TAP_UPD_DR) && selAccess &&
        ((scanOpc == `JDM_OPC_READ) || (scanOpc == `JDM_OPC_WRITE)); // [RQ1] [RQ5]
    wire [40:0] captureWord = {launch_r.addr, result_r, `JDM_OPC_OK}; // [RQ2] [RQ6]

    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            dr_r <= `JDM_SCAN_RESET; // [RQ4]
            bypass_r <= 1'b0;
        end else if (tap_r == TAP_CAP_DR) begin
            bypass_r <= 1'b0; // [RQ9]
            if (selAccess) begin
                dr_r <= captureWord; // [RQ2]
            end else if (selId) begin
                dr_r <= {9'h000, ID_VALUE};
            end else begin
                dr_r <= {9'h000, xportStatus};
            end
        end else if (tap_r == TAP_SHIFT_DR) begin
            bypass_r <= tdi; // [RQ9]
            if (selAccess) begin
                dr_r <= {tdi, dr_r[40:1]}; // [RQ4]
            end else begin
                dr_r <= {9'h000, tdi, dr_r[31:1]};
            end
        end
    end

    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            launch_r <= '0;
            reqTgl_r <= 1'b0;
        end else if (launchGo) begin
            launch_r.addr <= dr_r[`JDM_ADDR_HI:`JDM_ADDR_LO]; // [RQ7]
            launch_r.data <= dr_r[`JDM_DATA_HI:`JDM_DATA_LO];
            launch_r.opc <= scanOpc;
            reqTgl_r <= ~reqTgl_r; // [RQ22]
        end
    end

    // Result returns by toggle; the word is stable once the toggle is seen
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            ackSync1_r <= 1'b0;
            ackSync2_r <= 1'b0;
            ackSeen_r <= 1'b0;
            result_r <= 32'h0000_0000;
        end else begin
            ackSync1_r <= ackTgl_r;
            ackSync2_r <= ackSync1_r;
            ackSeen_r <= ackSync2_r;
            if (ackSync2_r != ackSeen_r) begin
                result_r <= respWord_r; // [RQ22]
            end
        end
    end

    // Data out changes on the falling edge
    always_ff @(negedge tck or posedge rst) begin
        if (rst) begin
            tdo <= 1'b0;
            tdoEn <= 1'b0;
        end else begin
            tdoEn <= (tap_r == TAP_SHIFT_DR) || (tap_r == TAP_SHIFT_IR);
            if (tap_r == TAP_SHIFT_IR) begin
                tdo <= irShift_r[0];
            end else if (selBypass) begin
                tdo <= bypass_r; // [RQ9]
            end else begin
                tdo <= dr_r[0];
            end
        end
    end

    // ======================================================
    // Request arrival (core clock)
    logic reqSync1_r;
    logic reqSync2_r;
    logic reqSeen_r;
    wire reqNew = reqSync2_r ^ reqSeen_r; // [RQ22]
    // Launch word is held until the next scan, which the debugger paces [RQ3]
    wire [6:0] modAddr = launch_r.addr - `JDM_MOD_BASE; // [RQ12]
    wire modWr = reqNew && (launch_r.opc == `JDM_OPC_WRITE);
    wire [31:0] wData = launch_r.data;
    wire wrCtl = modWr && (modAddr == `JDM_OFF_CONTROL);
    wire wrData0 = modWr && (modAddr == `JDM_OFF_DATA0);
    wire wrData1 = modWr && (modAddr == `JDM_OFF_DATA1);
    wire wrCmd = modWr && (modAddr == `JDM_OFF_COMMAND);
    wire wrSbAddr = modWr && (modAddr == `JDM_OFF_SB_ADDR);
    wire wrSbData0 = modWr && (modAddr == `JDM_OFF_SB_DATA0);
    wire wrSbData1 = modWr && (modAddr == `JDM_OFF_SB_DATA1);
    wire resumeGo = wrCtl && wData[`JDM_CTL_RESUMEREQ] &&
        !wData[`JDM_CTL_HALTREQ] && hartHalted; // [RQ16]
    wire ackResetGo = wrCtl && wData[`JDM_CTL_ACKRESET]; // [RQ18]

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reqSync1_r <= 1'b0;
            reqSync2_r <= 1'b0;
            reqSeen_r <= 1'b0;
        end else begin
            reqSync1_r <= reqTgl_r;
            reqSync2_r <= reqSync1_r;
            reqSeen_r <= reqSync2_r;
        end
    end

    // ======================================================
    // Debug module registers (core clock)
    logic [31:0] data0_r;
    logic [31:0] data1_r;
    logic [31:0] sbAddr_r;
    logic [31:0] sbData1_r;
    logic haltLatch_r;
    logic haveReset_r;
    logic resumeAck_r;
    logic [31:0] rdData;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data0_r <= 32'h0000_0000;
            data1_r <= 32'h0000_0000;
            sbAddr_r <= 32'h0000_0000;
            sbData1_r <= 32'h0000_0000;
            haltLatch_r <= 1'b0;
        end else begin
            if (wrData0) begin
                data0_r <= wData;
            end
            if (wrData1) begin
                data1_r <= wData;
            end
            if (wrSbAddr) begin
                sbAddr_r <= wData;
            end
            if (wrSbData1) begin
                sbData1_r <= wData;
            end
            if (wrCtl) begin
                haltLatch_r <= wData[`JDM_CTL_HALTREQ]; // [RQ15]
            end
        end
    end

    // Hart events win over a clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            haveReset_r <= 1'b0;
            resumeAck_r <= 1'b0;
        end else begin
            if (hartResetSeen) begin
                haveReset_r <= 1'b1;
            end else if (ackResetGo) begin
                haveReset_r <= 1'b0; // [RQ18]
            end
            if (hartResumed) begin
                resumeAck_r <= 1'b1;
            end else if (resumeGo) begin
                resumeAck_r <= 1'b0; // [RQ16]
            end
        end
    end

    // ======================================================
    // Read decode
    wire [31:0] statusWord = {9'h000, 3'h0, {2{haveReset_r}}, {2{resumeAck_r}}, 2'b00,
        {2{hartUnavail}}, {2{hartRunning}}, {2{hartHalted}}, 1'b1, 3'h0,
        `JDM_MOD_VERSION};
    wire [31:0] ctlWord = 32'h0000_0000; // [RQ15] [RQ16] [RQ17] [RQ18] [RQ19]

    always_comb begin
        if (modAddr == `JDM_OFF_DATA0) begin // [RQ11]
            rdData = data0_r;
        end else if (modAddr == `JDM_OFF_DATA1) begin
            rdData = data1_r;
        end else if (modAddr == `JDM_OFF_CONTROL) begin
            rdData = ctlWord;
        end else if (modAddr == `JDM_OFF_STATUS) begin
            rdData = statusWord;
        end else if (modAddr == `JDM_OFF_SB_ADDR) begin
            rdData = sbAddr_r;
        end else if (modAddr == `JDM_OFF_SB_DATA1) begin
            rdData = sbData1_r;
        end else if (modAddr == `JDM_OFF_HALT_SUMMARY) begin
            rdData = {31'h0000_0000, hartHalted};
        end else begin
            rdData = 32'h0000_0000;
        end
    end

    // ======================================================
    // Answer and hart, command and bus outputs (core clock)
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ackTgl_r <= 1'b0;
            respWord_r <= 32'h0000_0000;
        end else if (reqNew) begin
            ackTgl_r <= ~ackTgl_r; // [RQ22]
            respWord_r <= (launch_r.opc == `JDM_OPC_READ) ? rdData : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            resumeReq <= 1'b0;
            ackHaveReset <= 1'b0;
            absCmdValid <= 1'b0;
            absCmd <= 32'h0000_0000;
            sbReq <= '0;
        end else begin
            resumeReq <= resumeGo; // [RQ16]
            ackHaveReset <= ackResetGo; // [RQ18]
            absCmdValid <= wrCmd; // [RQ13]
            if (wrCmd) begin
                absCmd <= wData;
            end
            sbReq.valid <= wrSbData0; // [RQ13]
            if (wrSbData0) begin
                sbReq.write <= 1'b1;
                sbReq.addr <= sbAddr_r;
                sbReq.data <= wData;
            end
        end
    end

    assign haltReq = haltLatch_r; // [RQ15]

endmodule

// File: verif/jdm_access_assertions.sv
// Concurrent checks on the ports of the debug access block
`timescale 1ns/1ps

module jdm_access_assertions
    import jdm_pkg::*;
(
    // Clocks and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic tck,
    // JTAG pins
    input wire logic tms,
    input wire logic tdoEn,
    // Hart side
    input wire logic hartHalted,
    input wire logic haltReq,
    input wire logic resumeReq,
    input wire logic ackHaveReset,
    input wire logic absCmdValid,
    input wire jdm_sbreq_t sbReq
);
    // ==========================================================
    // Hart control
    a_resume_pulse: assert property (@(posedge clk) disable iff (rst)
        resumeReq |=> !resumeReq) else $error("resume request wider than one cycle");
    a_resume_cond: assert property (@(posedge clk) disable iff (rst)
        resumeReq |-> !haltReq && $past(hartHalted))
        else $error("resume while latched or not halted");
    a_ack_pulse: assert property (@(posedge clk) disable iff (rst)
        ackHaveReset |=> !ackHaveReset) else $error("reset acknowledge wider than one cycle");
    a_halt_alone: assert property (@(posedge clk) disable iff (rst)
        $changed(haltReq) |-> !absCmdValid && !sbReq.valid && !ackHaveReset)
        else $error("halt latch moved with another request");

    // ==========================================================
    // Command and bus paths
    a_abs_pulse: assert property (@(posedge clk) disable iff (rst)
        absCmdValid |=> !absCmdValid) else $error("abstract command wider than one cycle");
    a_sb_write: assert property (@(posedge clk) disable iff (rst)
        sbReq.valid |-> sbReq.write ##1 !sbReq.valid) else $error("bus request malformed");
    a_pulse_excl: assert property (@(posedge clk) disable iff (rst)
        !(absCmdValid && sbReq.valid)) else $error("one write raised two requests");

    // ==========================================================
    // TAP
    a_tap_reset: assert property (@(posedge tck) disable iff (rst)
        tms [*6] |-> !tdoEn) else $error("tdo enabled after TAP reset");
endmodule

bind jdm_access jdm_access_assertions u_chk (.clk(clk), .rst(rst), .tck(tck), .tms(tms),
    .tdoEn(tdoEn), .hartHalted(hartHalted), .haltReq(haltReq), .resumeReq(resumeReq),
    .ackHaveReset(ackHaveReset), .absCmdValid(absCmdValid), .sbReq(sbReq));

// File: verif/jdm_probe.sv
// JTAG debugger probe model driving the TAP
`timescale 1ns/1ps

module jdm_probe (
    // JTAG pins
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // One tck period; pins move while tck is low, tdo taken at the rise
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #62.5 tck = 1'b1;
        o = tdo;
        #62.5 tck = 1'b0;
    endtask

    task automatic tapReset();
        logic o;
        repeat (6) step(1'b1, ~tdi, o);
        step(1'b0, ~tdi, o);
    endtask

    // Full IR or DR scan from Run-Test/Idle, then idle so results can cross back
    task automatic scan(input logic ir, input logic [40:0] din, input int n,
                        output logic [40:0] dout);
        logic o;
        dout = '0;
        step(1'b1, ~tdi, o);
        if (ir) begin
            step(1'b1, ~tdi, o);
        end
        step(1'b0, ~tdi, o);
        step(1'b0, ~tdi, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, ~tdi, o);
        repeat (6) step(1'b0, ~tdi, o);
    endtask
endmodule

// File: verif/tb_top.sv
// Self-checking bench for the debug access block
`timescale 1ns/1ps

module tb_top;
    import jdm_pkg::*;
    logic clk, rst, tck, tms, tdi, tdo, tdoEn;
    logic hartHalted, hartRunning, hartUnavail, hartResetSeen, hartResumed;
    logic haltReq, resumeReq, ackHaveReset, absCmdValid;
    logic [31:0] absCmd, absSeen;
    jdm_sbreq_t sbReq, sbSeen;
    int badCount, nCompared, nResume, nAck, nAbs, nSb;
    logic [40:0] got;
    logic [4:0] irs [3] = '{5'h1F, 5'h00, 5'h12};
    logic [6:0] rwA [4] = '{7'h04, 7'h05, 7'h39, 7'h3D};
    logic [6:0] zA [4] = '{7'h16, 7'h38, 7'h20, 7'h3C};

    jdm_access DUT (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdoEn(tdoEn), .hartHalted(hartHalted), .hartRunning(hartRunning),
        .hartUnavail(hartUnavail), .hartResetSeen(hartResetSeen), .hartResumed(hartResumed),
        .haltReq(haltReq), .resumeReq(resumeReq), .ackHaveReset(ackHaveReset),
        .absCmdValid(absCmdValid), .absCmd(absCmd), .sbReq(sbReq));
    jdm_probe probe (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Counts one-cycle pulses from the core side
    always @(negedge clk) begin
        if (resumeReq === 1'b1) nResume++;
        if (ackHaveReset === 1'b1) nAck++;
        if (absCmdValid === 1'b1) begin
            nAbs++;
            absSeen = absCmd;
        end
        if (sbReq.valid === 1'b1) begin
            nSb++;
            sbSeen = sbReq;
        end
    end

    task automatic check(input string name, input logic [40:0] exp, input logic [40:0] act);
        nCompared++;
        if (act !== exp) begin
            badCount++;
            $display("ERROR %s expected %h seen %h", name, exp, act);
        end
    endtask

    task automatic accessScan(input logic [1:0] opc, input logic [6:0] a, input logic [31:0] d);
        probe.scan(1'b0, {a, d, opc}, 41, got);
    endtask

    // Read, then a nop scan that brings back address, data and a zero code
    task automatic rd(input logic [6:0] a, input logic [31:0] exp);
        accessScan(2'h1, a, 32'h0);
        accessScan(2'h0, 7'h00, 32'h0);
        check("read", {a, exp, 2'h0}, got);
    endtask

    task automatic reportAndStop();
        if (badCount == 0 && nCompared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        badCount++;
        reportAndStop();
    end

    initial begin
        rst = 1'b1;
        {hartHalted, hartRunning, hartUnavail, hartResetSeen, hartResumed} = 5'h00;
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        @(posedge clk);
        #1 hartResetSeen = 1'b1;
        @(posedge clk);
        #1 hartResetSeen = 1'b0;
        probe.tapReset();
        probe.scan(1'b1, 41'h1F, 5, got);
        check("ir capture", 41'h01, got);
        foreach (irs[i]) begin
            probe.scan(1'b1, {36'h0, irs[i]}, 5, got);
            probe.scan(1'b0, 41'hA5, 8, got);
            check("bypass", 41'h4A, got);
        end
        probe.scan(1'b1, 41'h10, 5, got);
        probe.scan(1'b0, 41'h0, 32, got);
        check("xport status", 41'h71, got);
        probe.scan(1'b1, 41'h11, 5, got);
        accessScan(2'h0, 7'h00, 32'h0);
        check("access reset", 41'h0, got);
        foreach (rwA[i]) begin
            accessScan(2'h2, rwA[i], 32'hA5C3_0F00 + i);
            rd(rwA[i], 32'hA5C3_0F00 + i);
        end
        accessScan(2'h0, 7'h04, 32'hFFFF_FFFF);
        rd(7'h04, 32'hA5C3_0F00);
        accessScan(2'h2, 7'h20, 32'hFFFF_FFFF);
        foreach (zA[i]) rd(zA[i], 32'h0);
        @(posedge clk);
        #1 hartHalted = 1'b1;
        rd(7'h11, 32'h000C_0382);
        accessScan(2'h2, 7'h10, 32'hAC00_0000);
        check("halt latch", 41'h1, {40'h0, haltReq});
        rd(7'h10, 32'h0);
        accessScan(2'h2, 7'h10, 32'hC000_0000);
        check("resume ignored", 41'h0, 41'(nResume));
        accessScan(2'h2, 7'h10, 32'h4000_0000);
        check("halt cleared", 41'h0, {40'h0, haltReq});
        check("resume", 41'h1, 41'(nResume));
        accessScan(2'h2, 7'h10, 32'h1000_0000);
        check("reset ack", 41'h1, 41'(nAck));
        @(posedge clk);
        #1 hartResumed = 1'b1;
        @(posedge clk);
        #1 hartResumed = 1'b0;
        rd(7'h11, 32'h0003_0382);
        rd(7'h40, 32'h1);
        @(posedge clk);
        #1 {hartHalted, hartRunning, hartUnavail} = 3'b011;
        rd(7'h11, 32'h0003_3C82);
        rd(7'h40, 32'h0);
        accessScan(2'h2, 7'h17, 32'h0022_1008);
        check("abs command", {9'h1, 32'h0022_1008}, {9'(nAbs), absSeen});
        accessScan(2'h2, 7'h39, 32'h8000_0040);
        accessScan(2'h2, 7'h3C, 32'h1234_5678);
        check("sb addr", {9'h1, 32'h8000_0040}, {9'(nSb), sbSeen.addr});
        check("sb data", {9'h1, 32'h1234_5678}, {8'h0, sbSeen.write, sbSeen.data});
        reportAndStop();
    end
endmodule
